// ### hw/cpcr_pkg.sv
package cpcr_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] CPCR_PROF_IDX = 8'h98;
    localparam logic [7:0] CPCR_TRAP_IDX = 8'h9a;
    localparam logic [9:0] CPCR_PROF_ADDR = {CPCR_PROF_IDX, 2'b00};
    localparam logic [9:0] CPCR_TRAP_ADDR = {CPCR_TRAP_IDX, 2'b00};
    localparam logic [31:0] CPCR_PROF_RST = 32'h0000_0000;
    localparam logic [31:0] CPCR_TRAP_RST = 32'h0000_0000;
    localparam int CPCR_STEP0_MSB = 30;
    localparam int CPCR_STEP_W = 3;
    localparam int CPCR_NSTEP = 8;
    localparam int CPCR_LEAD_LSB = 5;
    localparam int CPCR_HAND_LSB = 22;
    localparam int CPCR_NEG_LSB = 16;
    localparam int CPCR_HYST_BIT = 15;
    localparam int CPCR_EMF_LSB = 10;
    localparam int CPCR_CYC_LSB = 7;
    localparam int CPCR_ZC_LSB = 2;
    localparam int CPCR_DIV_LSB = 0;
    localparam logic [1:0] CPCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] CPCR_RESP_SLVERR = 2'h2;
    localparam logic [31:0] CPCR_UNMAPPED = 32'h0000_0000;
    localparam logic [12:0] CPCR_EMF_STEP = 13'h00c8;
    localparam logic [4:0] CPCR_CYC_BASE = 5'h02;
    localparam logic [4:0] CPCR_CYC_STEP = 5'h03;
    typedef enum logic [1:0] {CPCR_WR_IDLE, CPCR_WR_RESP} cpcr_wr_state_t;
endpackage

// ### hw/cpcr_cfg_if.sv
`timescale 1ns/1ps
interface cpcr_cfg_if;
    logic [31:0] profile;
    logic [31:0] trap;
    modport src (output profile, output trap);
    modport dec (input profile, input trap);
endinterface

// ### hw/cpcr_decode.sv
`timescale 1ns/1ps
module cpcr_decode (
    input wire logic clock,
    input wire logic rstn,
    cpcr_cfg_if.dec cfg,
    output logic [13:0] duty_q [8],
    output logic [4:0] lead_deg_q,
    output logic [4:0] handoff_cyc_q,
    output logic signed [6:0] neg_limit_q,
    output logic signed [7:0] pos_limit_q,
    output logic [12:0] emf_thr_q,
    output logic [4:0] isd_cyc_q,
    output logic [4:0] zc_deg_q,
    output logic [3:0] rate_div_q
);
    // duty in hundredths of a percent
    function automatic logic [13:0] duty_of(input logic [2:0] c);
        case (c)
            3'd0: duty_of = 14'd0;
            3'd1: duty_of = 14'd5000;
            3'd2: duty_of = 14'd7500;
            3'd3: duty_of = 14'd8375;
            3'd4: duty_of = 14'd8750;
            3'd5: duty_of = 14'd9375;
            3'd6: duty_of = 14'd9750;
            default: duty_of = 14'd9900;
        endcase
    endfunction
    function automatic logic signed [6:0] neg_of(input logic [2:0] c);
        case (c)
            3'd0: neg_of = 7'sd0;
            3'd1: neg_of = -7'sd40;
            3'd2: neg_of = -7'sd30;
            3'd3: neg_of = -7'sd20;
            3'd4: neg_of = -7'sd10;
            3'd5: neg_of = 7'sd10;
            3'd6: neg_of = 7'sd20;
            default: neg_of = 7'sd30;
        endcase
    endfunction
    logic [13:0] duty_d [8];
    logic [4:0] lead_d, hand_d, cyc_d, zc_d;
    logic signed [6:0] neg_d;
    logic signed [7:0] pos_d;
    logic [12:0] emf_d;
    logic [3:0] div_d;
    logic [2:0] ncode;
    always_comb begin
        ncode = cfg.trap[cpcr_pkg::CPCR_NEG_LSB +: 3];
        // one table for every step keeps step four on the same percent scale
        for (int i = 0; i < cpcr_pkg::CPCR_NSTEP; i++) begin
            duty_d[i] = duty_of(cfg.profile[cpcr_pkg::CPCR_STEP0_MSB - 2 - 3 * i +: 3]);
        end
        lead_d = 5'(5 * cfg.profile[cpcr_pkg::CPCR_LEAD_LSB +: 2]);
        hand_d = 5'(5'd3 << cfg.trap[cpcr_pkg::CPCR_HAND_LSB +: 2]);
        neg_d = neg_of(ncode);
        pos_d = 8'(neg_d) + (cfg.trap[cpcr_pkg::CPCR_HYST_BIT] ? 8'sd10 : 8'sd20);
        emf_d = 13'(cpcr_pkg::CPCR_EMF_STEP * cfg.trap[cpcr_pkg::CPCR_EMF_LSB +: 5]);
        cyc_d = 5'(cpcr_pkg::CPCR_CYC_BASE
            + cpcr_pkg::CPCR_CYC_STEP * cfg.trap[cpcr_pkg::CPCR_CYC_LSB +: 3]);
        case (cfg.trap[cpcr_pkg::CPCR_ZC_LSB +: 2])
            2'd0: zc_d = 5'd5;
            2'd1: zc_d = 5'd8;
            2'd2: zc_d = 5'd12;
            default: zc_d = 5'd15;
        endcase
        div_d = 4'(4'd1 << cfg.trap[cpcr_pkg::CPCR_DIV_LSB +: 2]);
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) duty_q[i] <= 14'd0;
            lead_deg_q <= 5'd0;
            handoff_cyc_q <= 5'd3;
            neg_limit_q <= 7'sd0;
            pos_limit_q <= 8'sd20;
            emf_thr_q <= 13'd0;
            isd_cyc_q <= 5'd2;
            zc_deg_q <= 5'd5;
            rate_div_q <= 4'd1;
        end else begin
            duty_q <= duty_d;
            lead_deg_q <= lead_d;
            handoff_cyc_q <= hand_d;
            neg_limit_q <= neg_d;
            pos_limit_q <= pos_d;
            emf_thr_q <= emf_d;
            isd_cyc_q <= cyc_d;
            zc_deg_q <= zc_d;
            rate_div_q <= div_d;
        end
    end
endmodule

// ### hw/cpcr_regs.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cpcr_regs (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [13:0] duty_q [8],
    output logic [4:0] lead_deg_q,
    output logic [4:0] handoff_cyc_q,
    output logic signed [6:0] neg_limit_q,
    output logic signed [7:0] pos_limit_q,
    output logic [12:0] emf_thr_q,
    output logic [4:0] isd_cyc_q,
    output logic [4:0] zc_deg_q,
    output logic [3:0] rate_div_q
);
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            merge[8 * b +: 8] = be[b] ? nw[8 * b +: 8] : old[8 * b +: 8];
        end
    endfunction

    cpcr_cfg_if cfg ();
    logic [31:0] prof_q, prof_d, trap_q, trap_d;
    logic [9:0] awaddr_q, awaddr_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_d, rvalid_d, arready_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;
    cpcr_pkg::cpcr_wr_state_t wst_q, wst_d;

    assign cfg.profile = prof_q;
    assign cfg.trap = trap_q;

    // write side: address and data latched independently, either order
    always_comb begin
        awaddr_d = awaddr_q;
        aw_have_d = aw_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        w_have_d = w_have_q;
        prof_d = prof_q;
        trap_d = trap_q;
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        wst_d = wst_q;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_d = s_axi_awaddr;
            aw_have_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
            w_have_d = 1'b1;
        end
        case (wst_q)
            cpcr_pkg::CPCR_WR_IDLE: begin
                if (aw_have_q && w_have_q) begin
                    bresp_d = cpcr_pkg::CPCR_RESP_OKAY;
                    if (awaddr_q == cpcr_pkg::CPCR_PROF_ADDR) begin
                        prof_d = merge(prof_q, wdata_q, wstrb_q);
                    end else if (awaddr_q == cpcr_pkg::CPCR_TRAP_ADDR) begin
                        trap_d = merge(trap_q, wdata_q, wstrb_q);
                    end else begin
                        bresp_d = cpcr_pkg::CPCR_RESP_SLVERR;
                    end
                    bvalid_d = 1'b1;
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    wst_d = cpcr_pkg::CPCR_WR_RESP;
                end
            end
            cpcr_pkg::CPCR_WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_d = 1'b0;
                    wst_d = cpcr_pkg::CPCR_WR_IDLE;
                end
            end
            default: wst_d = cpcr_pkg::CPCR_WR_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prof_q <= cpcr_pkg::CPCR_PROF_RST;
            trap_q <= cpcr_pkg::CPCR_TRAP_RST;
            awaddr_q <= 10'h000;
            aw_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cpcr_pkg::CPCR_RESP_OKAY;
            wst_q <= cpcr_pkg::CPCR_WR_IDLE;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            prof_q <= prof_d;
            trap_q <= trap_d;
            awaddr_q <= awaddr_d;
            aw_have_q <= aw_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            w_have_q <= w_have_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            wst_q <= wst_d;
            // ready only while that half is empty and no response pending
            s_axi_awready <= !aw_have_d && (wst_d == cpcr_pkg::CPCR_WR_IDLE)
                && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have_d && (wst_d == cpcr_pkg::CPCR_WR_IDLE)
                && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // read side: one outstanding read
    always_comb begin
        rvalid_d = s_axi_rvalid;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        arready_d = !s_axi_rvalid && !s_axi_arready;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            arready_d = 1'b0;
            rresp_d = cpcr_pkg::CPCR_RESP_OKAY;
            if (s_axi_araddr == cpcr_pkg::CPCR_PROF_ADDR) begin
                rdata_d = prof_q;
            end else if (s_axi_araddr == cpcr_pkg::CPCR_TRAP_ADDR) begin
                rdata_d = trap_q;
            end else begin
                rdata_d = cpcr_pkg::CPCR_UNMAPPED;
                rresp_d = cpcr_pkg::CPCR_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= cpcr_pkg::CPCR_RESP_OKAY;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
            s_axi_arready <= arready_d;
        end
    end

    cpcr_decode u_decode (
        .clock(clock),
        .rstn(rstn),
        .cfg(cfg.dec),
        .duty_q(duty_q),
        .lead_deg_q(lead_deg_q),
        .handoff_cyc_q(handoff_cyc_q),
        .neg_limit_q(neg_limit_q),
        .pos_limit_q(pos_limit_q),
        .emf_thr_q(emf_thr_q),
        .isd_cyc_q(isd_cyc_q),
        .zc_deg_q(zc_deg_q),
        .rate_div_q(rate_div_q)
    );

    wire prof_hit = s_axi_awaddr == cpcr_pkg::CPCR_PROF_ADDR;

    prof_reset_a: assert property (@(posedge clock)
        $rose(rstn) |-> prof_q == 32'h0000_0000 && trap_q == 32'h0000_0000)
        else $error("config not zero after reset");
    prof_write_a: assert property (@(posedge clock) disable iff (!rstn)
        wst_q == cpcr_pkg::CPCR_WR_IDLE && aw_have_q && w_have_q
        && awaddr_q == cpcr_pkg::CPCR_PROF_ADDR && wstrb_q == 4'hf
        |=> prof_q == $past(wdata_q))
        else $error("profile write lost");
    trap_write_a: assert property (@(posedge clock) disable iff (!rstn)
        wst_q == cpcr_pkg::CPCR_WR_IDLE && aw_have_q && w_have_q
        && awaddr_q == cpcr_pkg::CPCR_TRAP_ADDR && wstrb_q == 4'hf
        |=> trap_q == $past(wdata_q))
        else $error("trap write lost");
    step4_duty_a: assert property (@(posedge clock) disable iff (!rstn)
        prof_q[18:16] == 3'd7 && $stable(prof_q) |=> duty_q[4] == 14'd9900)
        else $error("step four decode wrong");
    step0_duty_a: assert property (@(posedge clock) disable iff (!rstn)
        prof_q[30:28] == 3'd3 && $stable(prof_q) |=> duty_q[0] == 14'd8375)
        else $error("step zero decode wrong");
    lead_angle_a: assert property (@(posedge clock) disable iff (!rstn)
        $stable(prof_q) |=> lead_deg_q == 5'(5 * $past(prof_q[6:5])))
        else $error("lead angle wrong");
    handoff_count_a: assert property (@(posedge clock) disable iff (!rstn)
        trap_q[23:22] == 2'd3 && $stable(trap_q) |=> handoff_cyc_q == 5'd24)
        else $error("handoff count wrong");
    neg_limit_a: assert property (@(posedge clock) disable iff (!rstn)
        trap_q[18:16] == 3'd1 && !trap_q[15] && $stable(trap_q)
        |=> neg_limit_q == -7'sd40 && pos_limit_q == -8'sd20)
        else $error("current limits wrong");
    hyst_select_a: assert property (@(posedge clock) disable iff (!rstn)
        trap_q[18:16] == 3'd0 && trap_q[15] && $stable(trap_q) |=> pos_limit_q == 8'sd10)
        else $error("hysteresis wrong");
    emf_thresh_a: assert property (@(posedge clock) disable iff (!rstn)
        trap_q[14:10] == 5'h1f && $stable(trap_q) |=> emf_thr_q == 13'd6200)
        else $error("emf threshold wrong");
    isd_cycles_a: assert property (@(posedge clock) disable iff (!rstn)
        trap_q[9:7] == 3'd7 && $stable(trap_q) |=> isd_cyc_q == 5'd23)
        else $error("isd cycles wrong");
    zc_angle_a: assert property (@(posedge clock) disable iff (!rstn)
        trap_q[3:2] == 2'd2 && $stable(trap_q) |=> zc_deg_q == 5'd12)
        else $error("zc angle wrong");
    rate_div_a: assert property (@(posedge clock) disable iff (!rstn)
        trap_q[1:0] == 2'd3 && $stable(trap_q) |=> rate_div_q == 4'd8)
        else $error("rate divider wrong");
    read_back_c: cover property (@(posedge clock) disable iff (!rstn) s_axi_rvalid && s_axi_rready);
    prof_wr_c: cover property (@(posedge clock) disable iff (!rstn)
        s_axi_awvalid && s_axi_awready && prof_hit);
    bad_addr_c: cover property (@(posedge clock) disable iff (!rstn)
        s_axi_bvalid && s_axi_bresp == cpcr_pkg::CPCR_RESP_SLVERR);
endmodule

// ### sim/test_commutation_profile_config_regs.sv
`timescale 1ns/1ps
module test_commutation_profile_config_regs;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] awaddr = 10'h000;
    logic [9:0] araddr = 10'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [13:0] duty_q [8];
    logic [4:0] lead_deg_q, handoff_cyc_q, isd_cyc_q, zc_deg_q;
    logic signed [6:0] neg_limit_q;
    logic signed [7:0] pos_limit_q;
    logic [12:0] emf_thr_q;
    logic [3:0] rate_div_q;
    int n_errors = 0;
    int checks_done = 0;
    int duty_tab [8] = '{0, 5000, 7500, 8375, 8750, 9375, 9750, 9900};
    int neg_tab [8] = '{0, -40, -30, -20, -10, 10, 20, 30};
    int zc_tab [4] = '{5, 8, 12, 15};
    localparam logic [9:0] PROF = cpcr_pkg::CPCR_PROF_ADDR;
    localparam logic [9:0] TRAP = cpcr_pkg::CPCR_TRAP_ADDR;

    always #10 clock = ~clock;

    cpcr_regs dut_u (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .duty_q(duty_q), .lead_deg_q(lead_deg_q), .handoff_cyc_q(handoff_cyc_q),
        .neg_limit_q(neg_limit_q), .pos_limit_q(pos_limit_q), .emf_thr_q(emf_thr_q),
        .isd_cyc_q(isd_cyc_q), .zc_deg_q(zc_deg_q), .rate_div_q(rate_div_q));

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_field(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // every wait is bounded so a silent slave cannot hang the run
    task automatic give_up();
        n_errors++;
        $display("Error bus answer expected within 50 cycles seen none");
        print_verdict();
    endtask

    task automatic axi_write(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        logic aw_done, w_done, b_done;
        int n;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_done = 1'b0;
        n = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_done) begin
            @(posedge clock);
            n++;
            if (n > 50) give_up();
            if (aw_done && w_done && bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                b_done = 1'b1;
            end
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
    endtask

    task automatic axi_read(input logic [9:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar_done, r_done;
        int n;
        ar_done = 1'b0;
        r_done = 1'b0;
        n = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_done) begin
            @(posedge clock);
            n++;
            if (n > 50) give_up();
            if (ar_done && rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                r_done = 1'b1;
            end
            if (!ar_done && arready) begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
        end
    endtask

    task automatic do_reset();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
    endtask

    task automatic scen_reset();
        logic [31:0] d;
        logic [1:0] r;
        chk_field("duty0", 16'h0000, 16'(duty_q[0]));
        chk_field("duty7", 16'h0000, 16'(duty_q[7]));
        chk_field("lead", 16'h0000, 16'(lead_deg_q));
        chk_field("handoff", 16'h0003, 16'(handoff_cyc_q));
        chk_field("neg", 16'h0000, 16'(neg_limit_q));
        chk_field("pos", 16'h0014, 16'(pos_limit_q));
        chk_field("emf", 16'h0000, 16'(emf_thr_q));
        chk_field("isd", 16'h0002, 16'(isd_cyc_q));
        chk_field("zc", 16'h0005, 16'(zc_deg_q));
        chk_field("div", 16'h0001, 16'(rate_div_q));
        axi_read(PROF, d, r);
        chk_word("profile reset", 32'h0000_0000, d);
        chk_resp("profile rresp", cpcr_pkg::CPCR_RESP_OKAY, r);
        axi_read(TRAP, d, r);
        chk_word("trap reset", 32'h0000_0000, d);
        chk_resp("trap rresp", cpcr_pkg::CPCR_RESP_OKAY, r);
    endtask

    // every step sees every code once across the eight passes of the rotation
    task automatic scen_profile();
        logic [31:0] v, d;
        logic [1:0] r;
        logic [2:0] c;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            v = 32'h0000_0000;
            v[31] = c[0];
            for (int i = 0; i < 8; i++) v[30 - 3 * i -: 3] = 3'(i + k);
            v[6:5] = c[1:0];
            v[4:0] = {c, 2'h1};
            axi_write(PROF, v, 4'hf, r);
            chk_resp("profile bresp", cpcr_pkg::CPCR_RESP_OKAY, r);
            axi_read(PROF, d, r);
            chk_word("profile", v, d);
            for (int i = 0; i < 8; i++) begin
                chk_field("duty", 16'(duty_tab[3'(i + k)]), 16'(duty_q[i]));
            end
            chk_field("lead", 16'(5 * c[1:0]), 16'(lead_deg_q));
        end
    endtask

    task automatic scen_trap();
        logic [31:0] v, d;
        logic [1:0] r;
        logic [2:0] c;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            // hysteresis bit opposite to the code's low bit so codes 0 and 1 meet both settings
            v = {c[0], 7'h55 ^ {4'h0, c}, c[1:0], ~c, c, ~c[0], {c, 2'h3}, c, c, c[1:0], ~c[1:0]};
            axi_write(TRAP, v, 4'hf, r);
            chk_resp("trap bresp", cpcr_pkg::CPCR_RESP_OKAY, r);
            axi_read(TRAP, d, r);
            chk_word("trap", v, d);
            chk_field("handoff", 16'(3 << c[1:0]), 16'(handoff_cyc_q));
            chk_field("neg", 16'(neg_tab[c]), 16'(neg_limit_q));
            chk_field("pos", 16'(neg_tab[c] + (c[0] ? 20 : 10)), 16'(pos_limit_q));
            chk_field("emf", 16'(200 * (4 * k + 3)), 16'(emf_thr_q));
            chk_field("isd", 16'(2 + 3 * k), 16'(isd_cyc_q));
            chk_field("zc", 16'(zc_tab[c[1:0]]), 16'(zc_deg_q));
            chk_field("div", 16'(1 << (3 - c[1:0])), 16'(rate_div_q));
        end
    endtask

    task automatic scen_strobe_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        axi_write(PROF, 32'h0000_0000, 4'hf, r);
        axi_write(PROF, 32'hffff_ffff, 4'h4, r);
        axi_write(PROF, 32'h1234_5678, 4'h9, r);
        axi_read(PROF, d, r);
        chk_word("profile lanes", 32'h12ff_0078, d);
        axi_write(10'h264, 32'hffff_ffff, 4'hf, r);
        chk_resp("unmapped bresp", cpcr_pkg::CPCR_RESP_SLVERR, r);
        axi_read(10'h264, d, r);
        chk_word("unmapped data", cpcr_pkg::CPCR_UNMAPPED, d);
        chk_resp("unmapped rresp", cpcr_pkg::CPCR_RESP_SLVERR, r);
        axi_read(PROF, d, r);
        chk_word("profile kept", 32'h12ff_0078, d);
        axi_read(TRAP, d, r);
        chk_word("trap kept", 32'hd2c7_7ffc, d);
    endtask

    initial begin
        do_reset();
        scen_reset();
        scen_profile();
        scen_trap();
        scen_strobe_unmapped();
        do_reset();
        scen_reset();
        print_verdict();
    end
endmodule
